// file: target_status_regs.svh
`ifndef TARGET_STATUS_REGS_SVH
`define TARGET_STATUS_REGS_SVH
// register byte offsets
`define OFS_CMD 8'h00
`define OFS_LBA 8'h04
`define OFS_LIMHI 8'h08
`define OFS_CTRL 8'h0C
`define OFS_STAT 8'h10
`define OFS_SENSE 8'h14
`define OFS_XS0 8'h18
`define OFS_XS1 8'h1C
// command word fields
`define CMD_INIT_LSB 24
`define CMD_CTL_LSB 16
`define CMD_B1_LSB 8
`define CMD_UNIT_LSB 13
`define CTL_LINK 0
`define CTL_IRQ 1
`define B1_WR_INH 0
`define B1_RD_INH 1
`define CTRL_GO 0
// status byte 0 bits
`define ST_CHECK 1
`define ST_EQUAL 2
`define ST_BUSY 3
`define ST_INTER 4
`define ST_EXT 7
// opcodes and groups
`define GRP_0 3'h0
`define GRP_1 3'h1
`define GRP_5 3'h5
`define GRP_CTL 3'h6
`define GRP_DIAG 3'h7
`define OP_SENSE 5'h03
`define OP_READ 5'h08
`define OP_WRITE 5'h0A
`define OP_LIMITS 5'h09
`define OP_RESERVE 5'h16
`define OP_RELEASE 5'h17
// sense keys
`define KEY_NONE 4'h0
`define KEY_RECOVER 4'h1
`define KEY_NOT_READY 4'h2
`define KEY_MEDIA 4'h3
`define KEY_HARDWARE 4'h4
`define KEY_ILLEGAL 4'h5
`define KEY_MEDIA_CHG 4'h6
`define KEY_PROTECT 4'h7
`define KEY_POWER 4'hA
`define KEY_ABORT 4'hB
// error classes and codes
`define CLS_DRIVE 3'h0
`define CLS_TARGET 3'h1
`define CLS_SYSTEM 3'h2
`define CLS_EXT 3'h7
`define EXT_CODE 4'h0
`define DRV_NONE 4'h0
`define DRV_NOT_READY 4'h4
`define DRV_NO_MEDIA 4'h9
`define TGT_DMA 4'h6
`define TGT_PROTECT 4'h7
`define TGT_CORRECTED 4'h8
`define TGT_INCOMPLETE 4'hB
`define SYS_INVALID 4'h0
`define SYS_BAD_ADDR 4'h1
`define ADD_SENSE_LEN 8'h00
// axi responses
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3
`endif

// file: target_status_pkg.sv
package target_status_pkg;
    typedef enum logic [1:0] {st_idle, st_exec} phase_t;
endpackage : target_status_pkg

// file: target_status_sense.sv
// The implementer's own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "target_status_regs.svh"
module target_status_sense
    import target_status_pkg::*;
#(
    parameter int NUM_INIT = 8
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // execution engine
    output logic exec_start,
    output logic [7:0] exec_opcode,
    output logic [31:0] exec_lba,
    output logic [2:0] exec_unit,
    output logic vendor_cmd,
    input wire logic exec_done,
    input wire logic exec_fault,
    input wire logic [2:0] fault_class,
    input wire logic [3:0] fault_code,
    input wire logic fault_addr_valid,
    input wire logic search_met,
    input wire logic unit_busy,
    // unit events
    input wire logic media_change,
    input wire logic power_fail,
    // status
    output logic status_ready
);

// ----------------------------------------------------------------
// helpers
// ----------------------------------------------------------------
function automatic logic [31:0] merge(input logic [31:0] old,
        input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
        if (s[i]) begin
            r[i*8 +: 8] = d[i*8 +: 8];
        end
    end
    return r;
endfunction : merge

function automatic logic in_limits(input logic [31:0] a,
        input logic [31:0] lo, input logic [31:0] hi);
    return (a >= lo) && (a <= hi);
endfunction : in_limits

// device-independent key from class and code
function automatic logic [3:0] key_of(input logic [2:0] c,
        input logic [3:0] e);
    logic [3:0] k;
    k = `KEY_HARDWARE;
    case (c)
        `CLS_DRIVE: begin
            if (e == `DRV_NONE) begin
                k = `KEY_NONE;
            end else if (e == `DRV_NOT_READY || e == `DRV_NO_MEDIA) begin
                k = `KEY_NOT_READY;
            end
        end
        `CLS_TARGET: begin
            case (e)
                `TGT_PROTECT: k = `KEY_PROTECT;
                `TGT_CORRECTED: k = `KEY_RECOVER;
                `TGT_DMA: k = `KEY_HARDWARE;
                `TGT_INCOMPLETE: k = `KEY_ABORT;
                default: k = `KEY_MEDIA;
            endcase
        end
        `CLS_SYSTEM: k = `KEY_ILLEGAL;
        default: k = `KEY_HARDWARE;
    endcase
    return k;
endfunction : key_of

// ----------------------------------------------------------------
// state
// ----------------------------------------------------------------
phase_t phase_r;
logic [31:0] cmd_r, lba_r, limhi_r, lim_lo_r, lim_hi_r;
logic [1:0] inh_r;
logic lim_act_r, chain_r, st_v_r, res_act_r;
logic [2:0] res_own_r;
logic [7:0] st_b0_r;
logic sv_r, s_av_r;
logic [2:0] s_cls_r, s_own_r, s_unit_r;
logic [3:0] s_code_r, s_key_r, attn_key_r;
logic [31:0] s_lba_r;
logic [NUM_INIT-1:0] attn_r;
logic aw_have_r, w_have_r;
logic [7:0] awaddr_r;
logic [31:0] wdata_r;
logic [3:0] wstrb_r;

wire [2:0] grp = cmd_r[7:5];
wire [4:0] code = cmd_r[4:0];
wire [7:0] ctl = cmd_r[`CMD_CTL_LSB +: 8];
wire [2:0] init = cmd_r[`CMD_INIT_LSB +: 3];
wire [2:0] unit = cmd_r[`CMD_UNIT_LSB +: 3];
wire grp_rw = grp == `GRP_0 || grp == `GRP_1;
wire is_wr = grp_rw && code == `OP_WRITE;
wire is_rw = is_wr || (grp_rw && code == `OP_READ);
wire is_sense = grp == `GRP_0 && code == `OP_SENSE;
wire is_limits = grp == `GRP_5 && code == `OP_LIMITS;
wire is_res = grp == `GRP_0 && code == `OP_RESERVE;
wire is_rel = grp == `GRP_0 && code == `OP_RELEASE;
wire in_lim = in_limits(lba_r, lim_lo_r, lim_hi_r);
wire inh = is_wr ? inh_r[`B1_WR_INH] : inh_r[`B1_RD_INH];

// ----------------------------------------------------------------
// axi4-lite write channel
// ----------------------------------------------------------------
wire wr_en = aw_have_r && w_have_r && !s_axi_bvalid;
wire wr_map = awaddr_r == `OFS_CMD || awaddr_r == `OFS_LBA ||
    awaddr_r == `OFS_LIMHI || awaddr_r == `OFS_CTRL;
wire go = wr_en && awaddr_r == `OFS_CTRL && wstrb_r[0] &&
    wdata_r[`CTRL_GO] && phase_r == st_idle;
assign s_axi_awready = !aw_have_r;
assign s_axi_wready = !w_have_r;

always_ff @(posedge aclk) begin
    if (!aresetn) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        awaddr_r <= 8'h00;
        wdata_r <= 32'h0000_0000;
        wstrb_r <= 4'h0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `RESP_OKAY;
    end else begin
        if (s_axi_awvalid && !aw_have_r) begin
            aw_have_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_have_r) begin
            w_have_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
        end
        if (wr_en) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_map ? `RESP_OKAY : `RESP_DECERR;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end
end

// command words are frozen while a command runs
always_ff @(posedge aclk) begin
    if (!aresetn) begin
        cmd_r <= 32'h0000_0000;
        lba_r <= 32'h0000_0000;
        limhi_r <= 32'h0000_0000;
    end else if (wr_en && phase_r == st_idle) begin
        if (awaddr_r == `OFS_CMD) begin
            cmd_r <= merge(cmd_r, wdata_r, wstrb_r);
        end
        if (awaddr_r == `OFS_LBA) begin
            lba_r <= merge(lba_r, wdata_r, wstrb_r);
        end
        if (awaddr_r == `OFS_LIMHI) begin
            limhi_r <= merge(limhi_r, wdata_r, wstrb_r);
        end
    end
end

// ----------------------------------------------------------------
// command decision
// ----------------------------------------------------------------
logic fin, f_chk, f_eq, f_busy, sset, s_av, start, lim_ld;
logic attn_take, clr_sense;
logic [2:0] s_cls;
logic [3:0] s_code, s_key;

always_comb begin
    fin = 1'b0;
    f_chk = 1'b0;
    f_eq = 1'b0;
    f_busy = 1'b0;
    sset = 1'b0;
    s_av = 1'b0;
    start = 1'b0;
    lim_ld = 1'b0;
    attn_take = 1'b0;
    clr_sense = 1'b0;
    s_cls = `CLS_SYSTEM;
    s_code = `SYS_INVALID;
    case (phase_r)
        st_idle: begin
            if (go && (unit_busy ||
                    (res_act_r && res_own_r != init))) begin
                fin = 1'b1;
                f_busy = 1'b1;
            end else if (go) begin
                clr_sense = !is_sense;
                if (attn_r[init] && !is_sense) begin
                    fin = 1'b1;
                    sset = 1'b1;
                    attn_take = 1'b1;
                    s_cls = `CLS_DRIVE;
                    s_code = `DRV_NONE;
                end else if (is_limits && lim_act_r) begin
                    fin = 1'b1;
                    sset = 1'b1;
                end else if (is_limits) begin
                    fin = 1'b1;
                    lim_ld = 1'b1;
                end else if (is_rw && lim_act_r && !in_lim) begin
                    fin = 1'b1;
                    sset = 1'b1;
                    s_av = 1'b1;
                    s_code = `SYS_BAD_ADDR;
                end else if (is_rw && lim_act_r && inh) begin
                    fin = 1'b1;
                    sset = 1'b1;
                    s_av = 1'b1;
                    if (is_wr) begin
                        s_cls = `CLS_TARGET;
                        s_code = `TGT_PROTECT;
                    end
                end else begin
                    start = 1'b1;
                end
            end
        end
        st_exec: begin
            if (exec_fault) begin
                fin = 1'b1;
                sset = 1'b1;
                s_cls = fault_class;
                s_code = fault_code;
                s_av = fault_addr_valid;
            end else if (exec_done) begin
                fin = 1'b1;
                f_eq = search_met;
                clr_sense = is_sense;
            end
        end
        default: begin
        end
    endcase
    f_chk = sset;
    s_key = attn_take ? attn_key_r : key_of(s_cls, s_code);
end

// linked and error-free means the chain goes on
wire inter = ctl[`CTL_LINK] && !f_chk && !f_busy;
wire store = !inter || ctl[`CTL_IRQ];
logic [7:0] b0;
always_comb begin
    b0 = 8'h00;
    b0[`ST_CHECK] = f_chk;
    b0[`ST_EQUAL] = f_eq;
    b0[`ST_BUSY] = f_busy;
    b0[`ST_INTER] = inter && ctl[`CTL_IRQ];
end

// ----------------------------------------------------------------
// sequencing, status and chain state
// ----------------------------------------------------------------
wire rd_stat = s_axi_arvalid && !s_axi_rvalid && s_axi_araddr == `OFS_STAT;
assign status_ready = st_v_r;

always_ff @(posedge aclk) begin
    if (!aresetn) begin
        phase_r <= st_idle;
        exec_start <= 1'b0;
        exec_opcode <= 8'h00;
        exec_lba <= 32'h0000_0000;
        exec_unit <= 3'h0;
        vendor_cmd <= 1'b0;
    end else begin
        exec_start <= start;
        if (start) begin
            phase_r <= st_exec;
            exec_opcode <= cmd_r[7:0];
            exec_lba <= lba_r;
            exec_unit <= unit;
            vendor_cmd <= grp == `GRP_CTL || grp == `GRP_DIAG;
        end else if (fin) begin
            phase_r <= st_idle;
        end
    end
end

always_ff @(posedge aclk) begin
    if (!aresetn) begin
        st_v_r <= 1'b0;
        st_b0_r <= 8'h00;
        chain_r <= 1'b0;
    end else begin
        if (rd_stat) begin
            st_v_r <= 1'b0;
        end
        if (fin && store) begin
            st_v_r <= 1'b1;
            st_b0_r <= b0;
        end
        if (fin) begin
            chain_r <= inter;
        end
    end
end

// limits live only for the rest of their own chain
always_ff @(posedge aclk) begin
    if (!aresetn) begin
        lim_act_r <= 1'b0;
        lim_lo_r <= 32'h0000_0000;
        lim_hi_r <= 32'h0000_0000;
        inh_r <= 2'h0;
    end else begin
        if (lim_ld) begin
            lim_lo_r <= lba_r;
            lim_hi_r <= limhi_r;
            inh_r <= cmd_r[`CMD_B1_LSB +: 2];
        end
        if (fin) begin
            lim_act_r <= inter && (lim_act_r || lim_ld);
        end
    end
end

always_ff @(posedge aclk) begin
    if (!aresetn) begin
        res_act_r <= 1'b0;
        res_own_r <= 3'h0;
    end else if (phase_r == st_exec && exec_done && !exec_fault) begin
        if (is_res) begin
            res_act_r <= 1'b1;
            res_own_r <= init;
        end else if (is_rel && res_own_r == init) begin
            res_act_r <= 1'b0;
        end
    end
end

// ----------------------------------------------------------------
// sense data and unit attention
// ----------------------------------------------------------------
always_ff @(posedge aclk) begin
    if (!aresetn) begin
        sv_r <= 1'b0;
        s_av_r <= 1'b0;
        s_cls_r <= `CLS_DRIVE;
        s_code_r <= `DRV_NONE;
        s_key_r <= `KEY_NONE;
        s_lba_r <= 32'h0000_0000;
        s_own_r <= 3'h0;
        s_unit_r <= 3'h0;
    end else begin
        if (clr_sense && s_own_r == init && s_unit_r == unit) begin
            sv_r <= 1'b0;
        end
        if (sset) begin
            sv_r <= 1'b1;
            s_av_r <= s_av;
            s_cls_r <= s_cls;
            s_code_r <= s_code;
            s_key_r <= s_key;
            s_lba_r <= lba_r;
            s_own_r <= init;
            s_unit_r <= unit;
        end
    end
end

// an event in the take cycle re-arms every initiator
always_ff @(posedge aclk) begin
    if (!aresetn) begin
        attn_r <= '0;
        attn_key_r <= `KEY_NONE;
    end else begin
        if (attn_take) begin
            attn_r[init] <= 1'b0;
        end
        if (power_fail) begin
            attn_r <= '1;
            attn_key_r <= `KEY_POWER;
        end else if (media_change) begin
            attn_r <= '1;
            attn_key_r <= `KEY_MEDIA_CHG;
        end
    end
end

// ----------------------------------------------------------------
// axi4-lite read channel
// ----------------------------------------------------------------
wire [31:0] sl = sv_r ? s_lba_r : 32'h0000_0000;
wire [7:0] nb0 = sv_r ? {s_av_r, s_cls_r, s_code_r} : 8'h00;
logic [31:0] rd_word;
logic rd_ok;
always_comb begin
    rd_ok = 1'b1;
    case (s_axi_araddr)
        `OFS_CMD: rd_word = cmd_r;
        `OFS_LBA: rd_word = lba_r;
        `OFS_LIMHI: rd_word = limhi_r;
        `OFS_CTRL: rd_word = {31'h0000_0000, phase_r != st_idle};
        `OFS_STAT: rd_word = {5'h00, s_own_r, 3'h0, sv_r, lim_act_r,
            chain_r, res_act_r, st_v_r, 8'h00, st_b0_r};
        `OFS_SENSE: rd_word = {sl[7:0], sl[15:8], 3'h0, sl[20:16],
            nb0};
        `OFS_XS0: rd_word = {sl[31:24], 4'h0, sv_r ? s_key_r : `KEY_NONE,
            8'h00, sv_r && s_av_r, `CLS_EXT, `EXT_CODE};
        `OFS_XS1: rd_word = {`ADD_SENSE_LEN, sl[7:0], sl[15:8],
            sl[23:16]};
        default: begin
            rd_word = 32'h0000_0000;
            rd_ok = 1'b0;
        end
    endcase
end

assign s_axi_arready = !s_axi_rvalid;
always_ff @(posedge aclk) begin
    if (!aresetn) begin
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= `RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_ok ? `RESP_OKAY : `RESP_DECERR;
    end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
    end
end

// ----------------------------------------------------------------
// checks
// ----------------------------------------------------------------
default clocking cb @(posedge aclk); endclocking
default disable iff (!aresetn);

sequence s_go_ok;
    go && !unit_busy && !(res_act_r && res_own_r != init) &&
        !(attn_r[init] && !is_sense);
endsequence
sequence s_pulse;
    exec_start ##1 !exec_start;
endsequence

property p_limit_refuse;
    s_go_ok ##0 (is_rw && lim_act_r && !in_lim) |=> !exec_start &&
        st_b0_r[`ST_CHECK] && s_code_r == `SYS_BAD_ADDR;
endproperty
a_limit_refuse: assert property (p_limit_refuse)
    else $error("access outside limits not refused");
property p_second_limits;
    s_go_ok ##0 (is_limits && lim_act_r) |=> st_b0_r[`ST_CHECK] &&
        s_key_r == `KEY_ILLEGAL && !lim_act_r;
endproperty
a_second_limits: assert property (p_second_limits)
    else $error("second limits command accepted");
property p_inhibit;
    s_go_ok ##0 (is_wr && lim_act_r && in_lim && inh_r[`B1_WR_INH])
        |=> !exec_start && s_key_r == `KEY_PROTECT;
endproperty
a_inhibit: assert property (p_inhibit)
    else $error("inhibited write started");
property p_fault_end;
    phase_r == st_exec && exec_fault |=> phase_r == st_idle &&
        st_v_r && st_b0_r[`ST_CHECK] && sv_r && !chain_r;
endproperty
a_fault_end: assert property (p_fault_end)
    else $error("fault did not end command with check");
property p_end_no_int;
    phase_r == st_exec && exec_done && !ctl[`CTL_LINK] |=>
        st_v_r && !st_b0_r[`ST_INTER] && !chain_r && !lim_act_r;
endproperty
a_end_no_int: assert property (p_end_no_int)
    else $error("ending status wrong");
property p_busy;
    go && unit_busy |=> st_b0_r[`ST_BUSY] && phase_r == st_idle &&
        !exec_start;
endproperty
a_busy: assert property (p_busy)
    else $error("busy unit took a command");
property p_equal;
    phase_r == st_exec && exec_done && !exec_fault && search_met &&
        !ctl[`CTL_LINK] |=> st_b0_r[`ST_EQUAL];
endproperty
a_equal: assert property (p_equal)
    else $error("equal bit missing");
property p_attn;
    media_change && !power_fail |=> &attn_r &&
        attn_key_r == `KEY_MEDIA_CHG;
endproperty
a_attn: assert property (p_attn)
    else $error("media change not posted to all");
property p_start;
    start |=> s_pulse ##0 phase_r == st_exec;
endproperty
a_start: assert property (p_start)
    else $error("execution start pulse wrong");

endmodule : target_status_sense

// file: exec_engine_model.sv
`timescale 1ns/1ps
// ------------------------------------------
// execution engine stand-in
// ------------------------------------------
module exec_engine_model (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // command side
    input wire logic exec_start,
    input wire logic [3:0] lat,
    input wire logic fault,
    output logic exec_done,
    output logic exec_fault
);
    int cnt_r;
    // one pulse lat+1 cycles after start; a fault ends the command instead
    always_ff @(posedge aclk) begin
        exec_done <= 1'b0;
        exec_fault <= 1'b0;
        if (!aresetn) begin
            cnt_r <= 0;
        end else if (exec_start) begin
            cnt_r <= int'(lat) + 1;
        end else if (cnt_r == 1) begin
            cnt_r <= 0;
            exec_done <= !fault;
            exec_fault <= fault;
        end else if (cnt_r > 1) begin
            cnt_r <= cnt_r - 1;
        end
    end
endmodule : exec_engine_model

// file: target_status_sense_tb.sv
`timescale 1ns/1ps
`include "target_status_regs.svh"
module target_status_sense_tb;
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
    logic bready = 1'b1, arvalid = 1'b0, rready = 1'b1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hF, fcode = 4'h0, lat = 4'h0;
    logic awready, wready, bvalid, arready, rvalid, exec_start, vendor_cmd;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, exec_lba;
    logic [7:0] exec_opcode;
    logic [2:0] exec_unit, fcls = 3'h0;
    logic exec_done, exec_fault, status_ready, fault = 1'b0, fav = 1'b0;
    logic smet = 1'b0, ubusy = 1'b0, mchg = 1'b0, pfail = 1'b0;
    logic [7:0] bl[5] = '{8'h01, 8'h01, 8'h02, 8'h00, 8'h01};
    logic [7:0] op[5] = '{8'h08, 8'h0A, 8'h08, 8'hA9, 8'h08};
    logic [31:0] ad[5] = '{32'd300, 32'd150, 32'd150, 32'd150, 32'd150};
    logic [7:0] sb[5] = '{8'h02, 8'h02, 8'h02, 8'h02, 8'h00};
    logic [3:0] ky[5] = '{4'h5, 4'h7, 4'h5, 4'h5, 4'h0};
    int fails = 0, checks = 0;

    always #4 aclk = ~aclk;

    target_status_sense dut_u (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .exec_start(exec_start),
        .exec_opcode(exec_opcode), .exec_lba(exec_lba),
        .exec_unit(exec_unit), .vendor_cmd(vendor_cmd),
        .exec_done(exec_done), .exec_fault(exec_fault), .fault_class(fcls),
        .fault_code(fcode), .fault_addr_valid(fav), .search_met(smet),
        .unit_busy(ubusy), .media_change(mchg), .power_fail(pfail),
        .status_ready(status_ready));

    exec_engine_model eng_u (.aclk(aclk), .aresetn(aresetn),
        .exec_start(exec_start), .lat(lat), .fault(fault),
        .exec_done(exec_done), .exec_fault(exec_fault));

    // ------------------------------------------
    // bus tasks and reference model
    // ------------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic complete_run();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : complete_run

    // bready stays high, so no wait on the answer can deadlock
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        chk("bresp", {30'h0, bresp}, 32'h0);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d,
            output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
    endtask : rd

    function automatic logic [31:0] cw(input logic [2:0] n,
            input logic [7:0] c, b, o);
        return {5'h0, n, c, b, o};
    endfunction : cw

    function automatic logic [3:0] key_of(input int c, e);
        if (c == 0) return (e == 0) ? 4'h0 : (e == 4 || e == 9) ? 4'h2 : 4'h4;
        if (c == 2) return 4'h5;
        if (e == 7 || e == 11) return 4'(e);
        return (e == 8) ? 4'h1 : (e == 6) ? 4'h4 : 4'h3;
    endfunction : key_of

    // issue one command, wait for idle, then fetch the status word
    task automatic cmd(input logic [31:0] c, l, h, output logic [31:0] st);
        logic [31:0] d;
        logic [1:0] r;
        wr(`OFS_CMD, c);
        wr(`OFS_LBA, l);
        wr(`OFS_LIMHI, h);
        wr(`OFS_CTRL, 32'h1);
        // only the watchdog ends a command that never finishes
        do begin
            rd(`OFS_CTRL, d, r);
        end while (d[0] !== 1'b0);
        rd(`OFS_STAT, st, r);
    endtask : cmd

    task automatic sense(input logic [2:0] c, input logic [3:0] e, k,
            input logic v, input logic [31:0] l);
        logic [31:0] d;
        logic [1:0] r;
        rd(`OFS_SENSE, d, r);
        chk("sense", d, {l[7:0], l[15:8], 3'h0, l[20:16], v, c, e});
        rd(`OFS_XS0, d, r);
        chk("xsense0", d, {l[31:24], 4'h0, k, 8'h00, v, 7'h70});
        rd(`OFS_XS1, d, r);
        chk("xsense1", d, {8'h00, l[7:0], l[15:8], l[23:16]});
    endtask : sense

    // ------------------------------------------
    // scenarios
    // ------------------------------------------
    initial begin
        logic [31:0] st, d, l;
        logic [1:0] r;
        int i, j;
        void'($urandom(95270));
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(8'h20, d, r);
        chk("decerr", {r, d[29:0]}, 32'hC0000000);
        smet <= 1'b1;
        cmd(cw(0, 0, 0, `OP_READ), 32'h10, 0, st);
        chk("status", st & 32'h1FFFF, 32'h10004);
        chk("ready", {31'h0, status_ready}, 32'h0);
        chk("vendor", {31'h0, vendor_cmd}, 32'h0);
        smet <= 1'b0;
        ubusy <= 1'b1;
        cmd(cw(0, 0, 0, `OP_READ), 32'h10, 0, st);
        chk("status", st & 32'h1FFFF, 32'h10008);
        ubusy <= 1'b0;
        cmd(cw(0, 8'h03, 0, `OP_READ), 32'h10, 0, st);
        chk("status", st & 32'h1FFFF, 32'h10010);
        cmd(cw(0, 8'h02, 0, `OP_READ), 32'h11, 0, st);
        chk("status", st & 32'h1FFFF, 32'h10000);
        for (i = 6; i < 8; i++) begin
            cmd(cw(0, 0, 0, {3'(i), 5'h01}), 32'h0, 0, st);
            chk("vendor", {31'h0, vendor_cmd}, 32'h1);
            chk("opcode", {24'h0, exec_opcode}, {24'h0, 3'(i), 5'h01});
        end
        fault <= 1'b1;
        for (i = 0; i < 36; i++) begin
            l = $urandom;
            fcls <= 3'(i / 12);
            fcode <= 4'(i % 12);
            fav <= 1'($urandom_range(1));
            lat <= 4'($urandom_range(9));
            cmd(cw(0, 0, 0, `OP_READ), l, 0, st);
            chk("status", st & 32'h1FFFF, 32'h10002);
            chk("lba", exec_lba, l);
            sense(fcls, fcode, key_of(i / 12, i % 12), fav, l);
        end
        fault <= 1'b0;
        cmd(cw(1, 0, 0, `OP_READ), 32'h0, 0, st);
        chk("sense_kept", {31'h0, st[20]}, 32'h1);
        cmd(cw(0, 0, 8'h20, `OP_READ), 32'h0, 0, st);
        chk("unit", {29'h0, exec_unit}, 32'h1);
        chk("sense_kept", {31'h0, st[20]}, 32'h1);
        cmd(cw(0, 0, 0, `OP_READ), 32'h0, 0, st);
        chk("sense_gone", {31'h0, st[20]}, 32'h0);
        for (i = 0; i < 5; i++) begin
            cmd(cw(0, 8'h01, bl[i], 8'hA9), 32'd100, 32'd200, st);
            cmd(cw(0, 0, 0, op[i]), ad[i], 32'd200, st);
            chk("limits", st & 32'h1FFFF, 32'h10000 | sb[i]);
            rd(`OFS_XS0, d, r);
            chk("limits_key", {28'h0, d[19:16]}, {28'h0, ky[i]});
        end
        for (i = 0; i < 2; i++) begin
            if (i == 0) mchg <= 1'b1;
            else pfail <= 1'b1;
            @(posedge aclk);
            mchg <= 1'b0;
            pfail <= 1'b0;
            for (j = 0; j < 3; j++) begin
                // the third command comes from the sense owner, clearing it
                cmd(cw((j == 0) ? 3'h0 : 3'h1, 0, 0, `OP_READ), 32'h0, 0,
                    st);
                chk("attn", st & 32'hFF, (j < 2) ? 32'h2 : 32'h0);
                rd(`OFS_XS0, d, r);
                chk("attn_key", {28'h0, d[19:16]},
                    (j < 2) ? (i == 0 ? 32'h6 : 32'hA) : 32'h0);
            end
        end
        complete_run();
    end

    initial begin
        #200us;
        fails++;
        complete_run();
    end
endmodule : target_status_sense_tb
